// file: logic/rtc_pkg.sv
// Purpose: constants and carriers for the real-time pattern compare engine
// Assumes: one 10 MHz clock, classic Wishbone register access, 32-bit data
// Notes:   every offset, field position, reset value and count lives here
package rtc_pkg;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned ADDR_W = 10;
  localparam int unsigned CLK_HZ = 10_000_000;

  // register byte offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_IRQ    = 8'h08;
  localparam logic [7:0] OFS_MASK   = 8'h0C;
  localparam logic [7:0] OFS_DELAY  = 8'h10;
  localparam logic [7:0] OFS_WIDTH  = 8'h14;
  localparam logic [7:0] OFS_TRIG   = 8'h18;
  localparam logic [7:0] OFS_STOP   = 8'h1C;
  localparam logic [7:0] OFS_PERIOD = 8'h20;
  localparam logic [7:0] OFS_ERRCNT = 8'h24;
  localparam logic [7:0] OFS_RESULT = 8'h28;
  localparam logic [7:0] OFS_MADDR  = 8'h2C;
  localparam logic [7:0] OFS_MEXP   = 8'h30;
  localparam logic [7:0] OFS_MMASK  = 8'h34;

  // control fields
  localparam int unsigned CTRL_RUN  = 0;
  localparam int unsigned CTRL_AUTO = 1;
  localparam int unsigned CTRL_SOE  = 2;
  localparam int unsigned CTRL_ACK  = 3;
  // status and interrupt fields
  localparam int unsigned ST_ACTIVE = 0;
  localparam int unsigned ST_FAILED = 1;
  localparam int unsigned ST_SHOW   = 2;
  localparam int unsigned IRQ_BLOCK = 0;
  localparam int unsigned IRQ_ERROR = 1;
  localparam int unsigned IRQ_W     = 2;

  // reset values
  localparam logic [ADDR_W-1:0] TRIG_MIN   = 10'h001;
  localparam logic [ADDR_W-1:0] RST_STOP   = 10'h04F;
  localparam logic [ADDR_W-1:0] RST_PERIOD = 10'h050;
  localparam logic [7:0]        RST_DELAY  = 8'h00;
  localparam logic [7:0]        RST_WIDTH  = 8'h01;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN  = 2'b01,
    ST_HOLD = 2'b10
  } phase_t;

  typedef struct packed {
    logic              cyc;
    logic              stb;
    logic              we;
    logic [3:0]        sel;
    logic [7:0]        adr;
    logic [31:0]       dat;
  } wb_req_t;

  typedef struct packed {
    logic [DATA_W-1:0] exp_bits;
    logic [DATA_W-1:0] care;
  } ref_word_t;
endpackage // rtc_pkg

// file: logic/realtime_pattern_compare.sv
// Purpose: real-time window compare of sampled words against reference memory
// Assumes: dut_data and dut_strobe are pins, synchronised here by two flops
// Notes:   window counts are clk cycles after each strobe; one word per strobe
`timescale 1ns/10ps
module realtime_pattern_compare #(
  parameter int unsigned DEPTH = 1 << rtc_pkg::ADDR_W
) (
  input  wire logic                      clk,
  input  wire logic                      nrst,
  input  wire rtc_pkg::wb_req_t          wb_req,
  output logic [31:0]                    wb_dat_o,
  output logic                           wb_ack_o,
  input  wire logic [rtc_pkg::DATA_W-1:0] dut_data,
  input  wire logic                      dut_strobe,
  output logic                           error_pulse,
  output logic                           irq
);
  localparam int unsigned AW = rtc_pkg::ADDR_W;
  localparam int unsigned DW = rtc_pkg::DATA_W;

  typedef struct packed {
    rtc_pkg::phase_t   phase;
    logic              ack;
    logic [31:0]       rdata;
    logic              autoc;
    logic              soe;
    logic [7:0]        delay;
    logic [7:0]        width;
    logic [AW-1:0]     trig;
    logic [AW-1:0]     stop;
    logic [AW-1:0]     period;
    logic [AW-1:0]     maddr;
    logic [AW-1:0]     raddr;
    logic [AW-1:0]     wcount;
    logic [7:0]        wincnt;
    logic              inwin;
    logic              sampled;
    logic [DW-1:0]     word;
    logic              failed;
    logic              show;
    logic [15:0]       errcnt;
    logic [AW-1:0]     result;
    logic [rtc_pkg::IRQ_W-1:0] ists;
    logic [rtc_pkg::IRQ_W-1:0] imask;
    logic              epulse;
    logic              irq;
  } state_t;

  state_t q, d;
  rtc_pkg::ref_word_t refmem [DEPTH];
  rtc_pkg::ref_word_t ref_rd;
  logic [DW-1:0] data_m, data_s;
  logic          strb_m, strb_s, strb_p;
  logic          mem_we;
  logic          mem_sel_exp;
  logic [DW-1:0] mem_wval;
  logic          show_set;

  // two-flop synchronisers for the pins, then an edge detector on stage two
  always_ff @(posedge clk) begin
    data_m <= dut_data;
    data_s <= data_m;
    strb_m <= dut_strobe;
    strb_s <= strb_m;
    strb_p <= strb_s;
  end

  // reference memory: written over the bus, read at the running address
  always_ff @(posedge clk) begin
    if (mem_we && mem_sel_exp) begin
      refmem[q.maddr].exp_bits <= mem_wval;
    end
    if (mem_we && !mem_sel_exp) begin
      refmem[q.maddr].care <= ~mem_wval;
    end
    ref_rd <= refmem[q.raddr];
  end

  wire bus_hit = wb_req.cyc && wb_req.stb && !q.ack;
  wire bus_wr  = bus_hit && wb_req.we && wb_req.sel[0];
  assign mem_we      = bus_wr && (wb_req.adr == rtc_pkg::OFS_MEXP ||
                                  wb_req.adr == rtc_pkg::OFS_MMASK);
  assign mem_sel_exp = wb_req.adr == rtc_pkg::OFS_MEXP;
  assign mem_wval    = wb_req.dat[DW-1:0];

  // mismatch on unmasked bits only, one cycle after the sample
  wire [DW-1:0] diff     = (q.word ^ ref_rd.exp_bits) & ref_rd.care;
  wire          mismatch = q.sampled && (diff != '0);
  wire          last_adr = q.raddr == q.period - 1'b1;

  // next-state logic: bus, window, compare and stop control
  always_comb begin
    d = q;
    d.ack     = bus_hit;
    d.epulse  = 1'b0;
    d.sampled = 1'b0;
    show_set  = 1'b0;
    if (bus_hit && !wb_req.we) begin
      unique case (wb_req.adr)
        rtc_pkg::OFS_CTRL:   d.rdata = {28'h0000000, 1'b0, q.soe, q.autoc,
                                        q.phase != rtc_pkg::ST_IDLE};
        rtc_pkg::OFS_STATUS: d.rdata = {29'h00000000, q.show, q.failed,
                                        q.phase == rtc_pkg::ST_RUN};
        rtc_pkg::OFS_IRQ:    d.rdata = {30'h00000000, q.ists};
        rtc_pkg::OFS_MASK:   d.rdata = {30'h00000000, q.imask};
        rtc_pkg::OFS_DELAY:  d.rdata = {24'h000000, q.delay};
        rtc_pkg::OFS_WIDTH:  d.rdata = {24'h000000, q.width};
        rtc_pkg::OFS_TRIG:   d.rdata = {22'h000000, q.trig};
        rtc_pkg::OFS_STOP:   d.rdata = {22'h000000, q.stop};
        rtc_pkg::OFS_PERIOD: d.rdata = {22'h000000, q.period};
        rtc_pkg::OFS_ERRCNT: d.rdata = {16'h0000, q.errcnt};
        rtc_pkg::OFS_RESULT: d.rdata = {22'h000000, q.result};
        rtc_pkg::OFS_MADDR:  d.rdata = {22'h000000, q.maddr};
        default:             d.rdata = 32'h00000000;
      endcase
    end
    // window: opens at the strobe edge, closes and samples after delay plus width cycles
    if (strb_s && !strb_p) begin
      d.wincnt = 8'h00;
      d.inwin  = 1'b1;
    end else if (q.inwin) begin
      d.wincnt = q.wincnt + 8'h01;
      if (q.wincnt == q.delay + q.width - 8'h01) begin
        d.inwin = 1'b0;
        d.sampled = q.phase == rtc_pkg::ST_RUN;
        d.word = data_s;
      end
    end
    // address step per word, wrap at the cycling period
    if (q.sampled) begin
      d.raddr  = last_adr ? '0 : q.raddr + 1'b1;
      d.wcount = q.wcount + 1'b1;
    end
    if (mismatch) begin
      d.failed = 1'b1;
      d.errcnt = q.errcnt + 16'h0001;
      d.epulse = !q.soe;
      d.ists[rtc_pkg::IRQ_ERROR] = 1'b1;
    end
    unique case (q.phase)
      rtc_pkg::ST_IDLE: ;
      rtc_pkg::ST_RUN: begin
        if (q.autoc) begin
          if (mismatch && q.soe) begin
            d.phase  = rtc_pkg::ST_HOLD;
            d.show   = 1'b1;
            show_set = 1'b1;
            d.result = q.raddr;
          end
        end else if (q.sampled && q.wcount == q.stop) begin
          d.phase  = rtc_pkg::ST_HOLD;
          d.show   = 1'b1;
          show_set = 1'b1;
          d.result = q.wcount;
          d.ists[rtc_pkg::IRQ_BLOCK] = 1'b1;
        end
      end
      rtc_pkg::ST_HOLD: ;                       // inputs ignored
      default: d.phase = rtc_pkg::ST_IDLE;
    endcase
    if (bus_wr) begin
      unique case (wb_req.adr)
        rtc_pkg::OFS_CTRL: begin
          d.autoc = wb_req.dat[rtc_pkg::CTRL_AUTO];
          d.soe   = wb_req.dat[rtc_pkg::CTRL_SOE];
          if (wb_req.dat[rtc_pkg::CTRL_RUN]) begin
            d.phase  = rtc_pkg::ST_RUN;
            // first word lands trig places before the wrap; trig must stay below period
            d.raddr  = q.period - q.trig;
            d.wcount = '0;
            d.errcnt = {15'h0000, mismatch};
            d.failed = mismatch;                // a late mismatch still wins
          end else begin
            d.phase = rtc_pkg::ST_IDLE;
          end
          if (wb_req.dat[rtc_pkg::CTRL_ACK]) begin
            d.show = show_set;                  // a stop in this cycle wins
          end
        end
        // write-one clears; a bit newly set in this same cycle survives, a repeat event on an already set bit does not
        rtc_pkg::OFS_IRQ:    d.ists = (q.ists & ~wb_req.dat[1:0]) | (d.ists & ~q.ists);
        rtc_pkg::OFS_MASK:   d.imask = wb_req.dat[1:0];
        rtc_pkg::OFS_DELAY:  d.delay = wb_req.dat[7:0];
        rtc_pkg::OFS_WIDTH:  d.width = (wb_req.dat[7:0] == 8'h00) ? 8'h01 : wb_req.dat[7:0];
        rtc_pkg::OFS_TRIG:   d.trig = (wb_req.dat[AW-1:0] < rtc_pkg::TRIG_MIN) ?
                                      rtc_pkg::TRIG_MIN : wb_req.dat[AW-1:0];
        rtc_pkg::OFS_STOP:   d.stop = wb_req.dat[AW-1:0];
        rtc_pkg::OFS_PERIOD: d.period = wb_req.dat[AW-1:0];
        rtc_pkg::OFS_MADDR:  d.maddr = wb_req.dat[AW-1:0];
        default: ;
      endcase
    end
    if (mem_we) begin
      d.maddr = q.maddr + 1'b1;
    end
    d.irq = |(d.ists & d.imask);
  end

  // single state register, synchronous active-low reset
  always_ff @(posedge clk) begin
    if (!nrst) begin
      q        <= '0;
      q.phase  <= rtc_pkg::ST_IDLE;
      q.trig   <= rtc_pkg::TRIG_MIN;
      q.stop   <= rtc_pkg::RST_STOP;
      q.period <= rtc_pkg::RST_PERIOD;
      q.delay  <= rtc_pkg::RST_DELAY;
      q.width  <= rtc_pkg::RST_WIDTH;
    end else begin
      q <= d;
    end
  end

  assign wb_ack_o    = q.ack;
  assign wb_dat_o    = q.rdata;
  assign error_pulse = q.epulse;
  assign irq         = q.irq;

  // trigger delay never drops below one word
  trig_floor_a: assert property (@(posedge clk) disable iff (!nrst)
    q.trig >= rtc_pkg::TRIG_MIN) else $error("trigger delay below one");
  // a mismatch with stop-on-error off pulses next cycle
  pulse_err_a: assert property (@(posedge clk) disable iff (!nrst)
    mismatch && !q.soe |=> error_pulse) else $error("missing error pulse");
  // hold ignores input: address frozen
  hold_freeze_a: assert property (@(posedge clk) disable iff (!nrst)
    q.phase == rtc_pkg::ST_HOLD && $stable(q.phase) |-> $stable(q.raddr))
    else $error("address moved in hold");
  // address wraps to zero at period end
  addr_wrap_a: assert property (@(posedge clk) disable iff (!nrst)
    q.sampled && last_adr && !bus_wr |=> q.raddr == '0) else $error("no wrap");
  // masked bits never count
  mask_ok_a: assert property (@(posedge clk) disable iff (!nrst)
    q.sampled && (((q.word ^ ref_rd.exp_bits) & ref_rd.care) == '0) && !bus_wr
    |=> !error_pulse && $stable(q.errcnt)) else $error("masked bit flagged");
  // any unmasked difference flags failure
  fail_set_a: assert property (@(posedge clk) disable iff (!nrst)
    mismatch && !bus_wr |=> q.failed) else $error("failure not flagged");
  // autocycle with soe stops on mismatch, display refreshed
  soe_stop_a: assert property (@(posedge clk) disable iff (!nrst)
    q.phase == rtc_pkg::ST_RUN && q.autoc && q.soe && mismatch && !bus_wr
    |=> q.phase == rtc_pkg::ST_HOLD && q.show) else $error("no stop on error");
  // clean run leaves the error count unchanged
  clean_run_a: assert property (@(posedge clk) disable iff (!nrst)
    q.phase == rtc_pkg::ST_RUN && !mismatch && !bus_wr |=> $stable(q.errcnt))
    else $error("count moved without error");
  // window closes after delay plus width cycles
  win_len_a: assert property (@(posedge clk) disable iff (!nrst)
    strb_s && !strb_p && q.delay == 8'h00 && q.width == 8'h01 && !bus_wr
    |=> ##1 !q.inwin || (strb_s && !strb_p)) else $error("window length");
  // bus handshake shape: ack one cycle after the taking edge, one cycle long
  ack_once_a: assert property (@(posedge clk) disable iff (!nrst)
    wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
  ack_next_a: assert property (@(posedge clk) disable iff (!nrst)
    bus_hit |=> wb_ack_o) else $error("ack not one cycle after request");
  // one-cycle pulse per mismatch with stop-on-error off, never without one
  pulse_once_a: assert property (@(posedge clk) disable iff (!nrst)
    error_pulse |=> !error_pulse) else $error("error pulse too long");
  pulse_cause_a: assert property (@(posedge clk) disable iff (!nrst)
    error_pulse |-> $past(mismatch) && !$past(q.soe))
    else $error("error pulse without mismatch");
  // interrupt level follows the unmasked sticky bits
  irq_level_a: assert property (@(posedge clk) disable iff (!nrst)
    irq == |(q.ists & q.imask)) else $error("irq level wrong");
  // a zero width would never sample, so it is forced to one
  width_floor_a: assert property (@(posedge clk) disable iff (!nrst)
    q.width != 8'h00) else $error("window width zero");
  // nothing is compared outside the running phase
  no_sample_a: assert property (@(posedge clk) disable iff (!nrst)
    q.phase != rtc_pkg::ST_RUN && $stable(q.phase) |-> !q.sampled)
    else $error("sample taken while stopped");
  // each counted error adds exactly one
  cnt_step_a: assert property (@(posedge clk) disable iff (!nrst)
    mismatch && !bus_wr |=> q.errcnt == $past(q.errcnt) + 16'h0001)
    else $error("error count step");
  // single block: last word sampled, then hold with display and block flag
  sequence block_end_s;
    q.phase == rtc_pkg::ST_RUN && !q.autoc && q.sampled && q.wcount == q.stop && !bus_wr;
  endsequence
  sequence block_shown_s;
    q.phase == rtc_pkg::ST_HOLD && q.show && q.ists[rtc_pkg::IRQ_BLOCK];
  endsequence
  block_stop_a: assert property (@(posedge clk) disable iff (!nrst)
    block_end_s |=> block_shown_s) else $error("no stop after block");
  // display refreshes only as a stop condition moves the engine to hold
  show_rise_a: assert property (@(posedge clk) disable iff (!nrst)
    $rose(q.show) |-> q.phase == rtc_pkg::ST_HOLD || $past(bus_wr))
    else $error("display refreshed without stop");
  // the shown result stays put while holding
  hold_result_a: assert property (@(posedge clk) disable iff (!nrst)
    q.phase == rtc_pkg::ST_HOLD && $stable(q.phase) |-> $stable(q.result))
    else $error("result moved in hold");
  // with stop-on-error off a mismatch does not stop the run
  soe_off_run_a: assert property (@(posedge clk) disable iff (!nrst)
    q.phase == rtc_pkg::ST_RUN && q.autoc && !q.soe && mismatch && !bus_wr
    |=> q.phase == rtc_pkg::ST_RUN) else $error("stopped with stop-on-error off");
  // failure flag is sticky until software restarts
  fail_sticky_a: assert property (@(posedge clk) disable iff (!nrst)
    q.failed && !bus_wr |=> q.failed) else $error("failure flag dropped");
  // a run command restarts the word count from zero
  sequence run_cmd_s;
    bus_wr && wb_req.adr == rtc_pkg::OFS_CTRL && wb_req.dat[rtc_pkg::CTRL_RUN];
  endsequence
  run_start_a: assert property (@(posedge clk) disable iff (!nrst)
    run_cmd_s |=> q.phase == rtc_pkg::ST_RUN && q.wcount == '0)
    else $error("run did not restart");
endmodule // realtime_pattern_compare

// file: sim/stim_source.sv
// Purpose: pattern generator plus device under test, far side of the engine
// Assumes: eight-word pattern, one word per eight clocks
// Notes:   idle strobe stands low and idle data churns every cycle
`timescale 1ns/10ps
module stim_source (
  input  wire logic         clk,
  input  wire logic         en,
  input  wire logic [127:0] pat,
  input  wire logic [2:0]   flip_idx,
  input  wire logic [15:0]  flip_bits,
  output logic [15:0]       dut_data,
  output logic              dut_strobe
);
  logic [2:0] cnt;
  logic [2:0] idx;
  initial dut_data = 16'h0000;
  // data held for the whole strobe period, so any window with delay plus width up to seven fits
  always @(posedge clk) begin
    if (!en) begin
      cnt <= 3'h0;
      idx <= 3'h0;
      dut_strobe <= 1'b0;
      dut_data <= ~dut_data; // released lines keep no value
    end else begin
      cnt <= cnt + 3'h1;
      dut_strobe <= (cnt < 3'h4);
      if (cnt == 3'h0) begin
        dut_data <= pat[idx*16 +: 16] ^ ((idx == flip_idx) ? flip_bits : 16'h0000);
        idx <= idx + 3'h1;
      end
    end
  end
endmodule // stim_source

// file: sim/realtime_pattern_compare_tb.sv
// Purpose: self-checking bench for the real-time pattern compare engine
// Assumes: eight-word pattern, stop 7, period 8, seed 95
// Notes:   expectations come from the pattern table only
`timescale 1ns/10ps
module realtime_pattern_compare_tb;
  logic             clk = 1'b0;
  logic             nrst = 1'b0;
  rtc_pkg::wb_req_t wb_req = '0;
  logic [31:0]      wb_dat_o;
  logic [31:0]      rd;
  logic             wb_ack_o, error_pulse, irq, dut_strobe;
  logic             en = 1'b0;
  logic [15:0]      dut_data;
  logic [15:0]      flip_bits = 16'h0000;
  logic [127:0]     pat;
  int               fails = 0, n_checks = 0, pulses = 0, mbit, ubit;
  realtime_pattern_compare dut_u (.clk(clk), .nrst(nrst), .wb_req(wb_req),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .dut_data(dut_data),
    .dut_strobe(dut_strobe), .error_pulse(error_pulse), .irq(irq));
  stim_source src_u (.clk(clk), .en(en), .pat(pat), .flip_idx(3'h5),
    .flip_bits(flip_bits), .dut_data(dut_data), .dut_strobe(dut_strobe));
  always #50 clk = ~clk;
  // tally of mismatch pulses, cleared by each run
  always @(posedge clk) if (error_pulse === 1'b1) pulses++;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one classic cycle; waits for ack however long it takes
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wb_req <= '{1'b1, 1'b1, w, 4'hF, a, d};
    do begin
      @(posedge clk);
    end while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_req <= '0;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk(rd & m, e);
  endtask
  // restart the engine so its reference address realigns with word zero
  task automatic run(input logic [31:0] ctrl, input int n);
    wb(1'b1, rtc_pkg::OFS_CTRL, 32'h0);
    wb(1'b1, rtc_pkg::OFS_IRQ, 32'h3);
    wb(1'b1, rtc_pkg::OFS_CTRL, ctrl);
    pulses = 0;
    en <= 1'b1;
    repeat (n * 64) @(posedge clk);
    en <= 1'b0;
    repeat (20) @(posedge clk);
  endtask
  task automatic irqchk(input logic e);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, {31'h0, e});
  endtask
  // expected memory holds the second word first, the first word last
  function automatic logic [15:0] ref_word(input int k);
    return pat[((k + 1) % 8)*16 +: 16];
  endfunction
  task automatic finish_test;
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    #2_000_000;
    fails++;
    finish_test;
  end
  initial begin
    void'($urandom(95));
    for (int i = 0; i < 8; i++) pat[i*16 +: 16] = 16'($urandom);
    mbit = $urandom % 16;
    ubit = (mbit + 1 + $urandom % 15) % 16;
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    rdchk(rtc_pkg::OFS_DELAY, 32'hFF, 32'h0);
    rdchk(rtc_pkg::OFS_WIDTH, 32'hFF, 32'h1);
    rdchk(8'h40, 32'hFFFFFFFF, 32'h0);
    wb(1'b1, rtc_pkg::OFS_TRIG, 32'h0);
    rdchk(rtc_pkg::OFS_TRIG, 32'h3FF, 32'h1);
    wb(1'b1, rtc_pkg::OFS_STOP, 32'h7);
    wb(1'b1, rtc_pkg::OFS_PERIOD, 32'h8);
    wb(1'b1, rtc_pkg::OFS_MASK, 32'h3);
    for (int k = 0; k < 8; k++) begin
      wb(1'b1, rtc_pkg::OFS_MADDR, 32'(k));
      wb(1'b1, rtc_pkg::OFS_MEXP, {16'h0, ref_word(k)});
      wb(1'b1, rtc_pkg::OFS_MADDR, 32'(k));
      wb(1'b1, rtc_pkg::OFS_MMASK, (k == 4) ? 32'h1 << mbit : 32'h0);
    end
    $display("test setup done");
    run(32'h3, 4);
    chk(32'(pulses), 32'h0);
    rdchk(rtc_pkg::OFS_STATUS, 32'h3, 32'h1);
    rdchk(rtc_pkg::OFS_ERRCNT, 32'hFFFF, 32'h0);
    flip_bits <= 16'h1 << mbit;
    run(32'h3, 3);
    chk(32'(pulses), 32'h0);
    flip_bits <= 16'h1 << ubit;
    run(32'h3, 3);
    chk(32'(pulses), 32'h3);
    $display("test autocycle done");
    run(32'h7, 2);
    rdchk(rtc_pkg::OFS_STATUS, 32'h7, 32'h6);
    rdchk(rtc_pkg::OFS_RESULT, 32'h3FF, 32'h4);
    irqchk(1'b1);
    wb(1'b1, rtc_pkg::OFS_MASK, 32'h0);
    irqchk(1'b0);
    wb(1'b1, rtc_pkg::OFS_MASK, 32'h3);
    irqchk(1'b1);
    wb(1'b1, rtc_pkg::OFS_IRQ, 32'h3);
    irqchk(1'b0);
    $display("test stop on error done");
    flip_bits <= 16'h0;
    wb(1'b1, rtc_pkg::OFS_WIDTH, 32'h0);
    rdchk(rtc_pkg::OFS_WIDTH, 32'hFF, 32'h1);
    wb(1'b1, rtc_pkg::OFS_DELAY, 32'h2);
    wb(1'b1, rtc_pkg::OFS_WIDTH, 32'h3);
    run(32'h1, 2);
    rdchk(rtc_pkg::OFS_IRQ, 32'h1, 32'h1);
    rdchk(rtc_pkg::OFS_STATUS, 32'h1, 32'h0);
    rdchk(rtc_pkg::OFS_RESULT, 32'h3FF, 32'h7);
    $display("test single block done");
    nrst <= 1'b0;
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    rdchk(rtc_pkg::OFS_STATUS, 32'h7, 32'h0);
    rdchk(rtc_pkg::OFS_STOP, 32'h3FF, 32'(rtc_pkg::RST_STOP));
    rdchk(rtc_pkg::OFS_PERIOD, 32'h3FF, 32'(rtc_pkg::RST_PERIOD));
    $display("test reset done");
    finish_test;
  end
endmodule // realtime_pattern_compare_tb
